//--- inc/fault_mute_regs.svh
`ifndef FAULT_MUTE_REGS_SVH
`define FAULT_MUTE_REGS_SVH
// ==========================================================
// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_IRQ_STAT 8'h08
`define OFF_IRQ_MASK 8'h0c
`define OFF_FWD_THR 8'h10
`define OFF_REV_THR 8'h14
// ==========================================================
// field positions
`define CTRL_RED_EN 0
`define ST_FAULT 0
`define ST_THERM 1
`define ST_SHUTDOWN 2
`define ST_MUTED 3
`define ST_PWR_ALARM 4
`define ST_COIL 5
`define ST_PARTNER 6
`define ST_RED_LSB 8
`define EV_FAULT 0
`define EV_THERM 1
`define EV_PWR 2
`define EV_PARTNER 3
`define EV_W 4
// ==========================================================
// reset values
`define RST_CTRL 1'b1
`define RST_FWD_THR 12'h000
`define RST_REV_THR 12'hfff
// ==========================================================
// limits, degrees c and amperes
`define TEMP_FAULT_C 8'h50
`define TEMP_ALARM_C 8'h46
`define TEMP_RESTART_C 8'h41
`define CURRENT_FAULT_A 8'h96
`endif

//--- inc/fault_mute_pkg.sv
`default_nettype none
package fault_mute_pkg;
  // ==========================================================
  // redundancy switch states
  typedef enum logic [2:0] {
    RED_NORMAL = 3'b001,
    RED_TAKEOVER = 3'b010,
    RED_BOTH_BAD = 3'b100
  } red_e;
  // ==========================================================
  // top level state
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic red_en;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [11:0] fwd_thr;
    logic [11:0] rev_thr;
    logic ser_mute;
    red_e red;
    logic relay;
    logic rf_dis;
    logic coil;
    logic fwd_fault;
    logic pwr_alarm;
    logic irq;
    logic [3:0] prev_ev;
    logic uart_v;
    logic rs_v;
    logic [7:0] code;
    logic [7:0] last;
  } top_s;
endpackage
`default_nettype wire

//--- rtl/pin_sync.sv
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  // ==========================================================
  // three stages, output follows once stages two and three agree
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_s;
  sync_s q, d;
  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 ^ q.s3));
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end
  assign level_o = q.lvl;
endmodule // pin_sync
`default_nettype wire

//--- rtl/hyst_cmp.sv
`default_nettype none
module hyst_cmp #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] value_i,
  input wire logic [W-1:0] set_above_i,
  input wire logic [W-1:0] clear_at_i,
  output logic active_o
);
  // ==========================================================
  // set above upper limit, clear at or below lower limit
  typedef struct packed {
    logic act;
  } hyst_s;
  hyst_s q, d;
  always_comb begin
    d = q;
    if (value_i > set_above_i) begin
      d.act = 1'b1;
    end else if (value_i <= clear_at_i) begin
      d.act = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end
  assign active_o = q.act;
endmodule // hyst_cmp
`default_nettype wire

//--- rtl/fault_mute_supervisor.sv
// Implementation choices: the Wishbone slave port and the register offsets.
`include "fault_mute_regs.svh"
`default_nettype none
module fault_mute_supervisor
  import fault_mute_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] pc_fault_i,
  input wire logic lo_unlock_i,
  input wire logic fet_fail_i,
  input wire logic mute_loop_closed_i,
  input wire logic partner_fault_i,
  input wire logic [7:0] baseplate_temp_i,
  input wire logic [7:0] internal_temp_i,
  input wire logic [7:0] supply_current_i,
  input wire logic [11:0] fwd_power_i,
  input wire logic [11:0] rev_power_i,
  input wire logic mute_cmd_i,
  input wire logic enable_cmd_i,
  input wire logic uart_ready_i,
  input wire logic rs485_ready_i,
  output logic fault_relay_on_o,
  output logic rf_disable_o,
  output logic thermal_alarm_o,
  output logic power_alarm_o,
  output logic switch_coil_o,
  output logic fault_to_partner_o,
  output logic uart_msg_valid_o,
  output logic [7:0] uart_msg_o,
  output logic rs485_msg_valid_o,
  output logic [7:0] rs485_msg_o,
  output logic irq_o
);
  // ==========================================================
  // helpers
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction

  // ==========================================================
  // pin inputs
  logic [5:0] pins;
  logic [1:0] pc_fault;
  logic lo_unlock;
  logic fet_fail;
  logic loop_closed;
  logic partner_fault;
  logic therm_alarm;
  logic shutdown;

  pin_sync #(
    .W(6)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i({pc_fault_i, lo_unlock_i, fet_fail_i, mute_loop_closed_i, partner_fault_i}),
    .level_o(pins)
  );
  assign pc_fault = pins[5:4];
  assign lo_unlock = pins[3];
  assign fet_fail = pins[2];
  assign loop_closed = pins[1];
  assign partner_fault = pins[0];

  // ==========================================================
  // thermal supervision
  hyst_cmp #(
    .W(8)
  ) u_alarm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .value_i(internal_temp_i),
    .set_above_i(`TEMP_ALARM_C),
    .clear_at_i(`TEMP_RESTART_C),
    .active_o(therm_alarm)
  );

  hyst_cmp #(
    .W(8)
  ) u_shutdown (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .value_i(internal_temp_i),
    .set_above_i(`TEMP_FAULT_C),
    .clear_at_i(`TEMP_RESTART_C),
    .active_o(shutdown)
  );

  // ==========================================================
  // state
  top_s q, d;
  logic temp_hi;
  logic cur_hi;
  logic fault;
  logic muted;
  logic pwr_alarm;
  logic [7:0] code_now;
  logic [3:0] ev;
  logic wr;
  logic rd;
  logic [31:0] status;
  // write data merged into the ctrl, irq mask and threshold registers through their byte lanes
  logic [31:0] m_ctrl;
  logic [31:0] m_mask;
  logic [31:0] m_fwd;
  logic [31:0] m_rev;

  always_comb begin
    temp_hi = baseplate_temp_i > `TEMP_FAULT_C;
    cur_hi = supply_current_i > `CURRENT_FAULT_A;
    fault = (|pc_fault) | lo_unlock | fet_fail | temp_hi | cur_hi;
    muted = q.ser_mute | ~loop_closed;
    pwr_alarm = (rev_power_i > q.rev_thr) | (fwd_power_i < q.fwd_thr);
    code_now = {1'b0, fault, pc_fault, cur_hi, temp_hi, fet_fail, lo_unlock};
    ev = '0;
    ev[`EV_FAULT] = fault;
    ev[`EV_THERM] = therm_alarm;
    ev[`EV_PWR] = pwr_alarm;
    ev[`EV_PARTNER] = partner_fault;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & ~q.ack;
    rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~q.ack;
    status = '0;
    status[`ST_FAULT] = ~q.relay;
    status[`ST_THERM] = therm_alarm;
    status[`ST_SHUTDOWN] = shutdown;
    status[`ST_MUTED] = muted;
    status[`ST_PWR_ALARM] = q.pwr_alarm;
    status[`ST_COIL] = q.coil;
    status[`ST_PARTNER] = partner_fault;
    status[`ST_RED_LSB +: 3] = q.red;
    // lanes not selected keep the old register contents
    m_ctrl = lane_merge({31'h0, q.red_en}, wb_dat_i, wb_sel_i);
    m_mask = lane_merge({28'h0, q.irq_mask}, wb_dat_i, wb_sel_i);
    m_fwd = lane_merge({20'h0, q.fwd_thr}, wb_dat_i, wb_sel_i);
    m_rev = lane_merge({20'h0, q.rev_thr}, wb_dat_i, wb_sel_i);
  end

  always_comb begin
    d = q;
    // bus slave, one wait state, unmapped reads return zero
    d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    d.dat = '0;
    if (rd) begin
      case (1'b1)
        hit(wb_adr_i, `OFF_CTRL): d.dat = {31'h0, q.red_en};
        hit(wb_adr_i, `OFF_STATUS): d.dat = status;
        hit(wb_adr_i, `OFF_IRQ_STAT): d.dat = {28'h0, q.irq_stat};
        hit(wb_adr_i, `OFF_IRQ_MASK): d.dat = {28'h0, q.irq_mask};
        hit(wb_adr_i, `OFF_FWD_THR): d.dat = {20'h0, q.fwd_thr};
        hit(wb_adr_i, `OFF_REV_THR): d.dat = {20'h0, q.rev_thr};
        default: d.dat = '0;
      endcase
    end
    if (wr && hit(wb_adr_i, `OFF_CTRL)) begin
      d.red_en = m_ctrl[`CTRL_RED_EN];
    end
    if (wr && hit(wb_adr_i, `OFF_IRQ_MASK)) begin
      d.irq_mask = m_mask[3:0];
    end
    if (wr && hit(wb_adr_i, `OFF_FWD_THR)) begin
      d.fwd_thr = m_fwd[11:0];
    end
    if (wr && hit(wb_adr_i, `OFF_REV_THR)) begin
      d.rev_thr = m_rev[11:0];
    end
    // sticky events, a new event wins over a write-one clear
    d.prev_ev = ev;
    if (wr && hit(wb_adr_i, `OFF_IRQ_STAT) && wb_sel_i[0]) begin
      d.irq_stat = q.irq_stat & ~wb_dat_i[3:0];
    end
    d.irq_stat = d.irq_stat | (ev & ~q.prev_ev);
    d.irq = |(d.irq_stat & d.irq_mask);

    // serial mute state, a mute request beats an enable
    if (mute_cmd_i) begin
      d.ser_mute = 1'b1;
    end else if (enable_cmd_i) begin
      d.ser_mute = 1'b0;
    end
    // shared disable line to both boards
    d.rf_dis = d.ser_mute | ~loop_closed | lo_unlock | shutdown;
    // relay held energised only while no fault is present
    d.relay = ~fault;
    d.fwd_fault = fault;
    d.pwr_alarm = pwr_alarm;

    // redundancy switch control
    case (q.red)
      RED_NORMAL: begin
        if (partner_fault && !fault) begin
          d.red = RED_TAKEOVER;
        end else if (partner_fault && fault) begin
          d.red = RED_BOTH_BAD;
        end
      end
      RED_TAKEOVER: begin
        if (!partner_fault) begin
          d.red = RED_NORMAL;
        end else if (fault) begin
          d.red = RED_BOTH_BAD;
        end
      end
      RED_BOTH_BAD: begin
        if (!partner_fault) begin
          d.red = RED_NORMAL;
        end else if (!fault) begin
          d.red = RED_TAKEOVER;
        end
      end
      default: d.red = RED_NORMAL;
    endcase
    if (!q.red_en) begin
      d.red = RED_NORMAL;
    end
    // coil energised only while this unit has taken over
    d.coil = d.red == RED_TAKEOVER;

    // fault message on both links whenever the fault picture changes
    if (q.uart_v && uart_ready_i) begin
      d.uart_v = 1'b0;
    end
    if (q.rs_v && rs485_ready_i) begin
      d.rs_v = 1'b0;
    end
    if (!d.uart_v && !d.rs_v && !q.uart_v && !q.rs_v && code_now != q.last) begin
      d.code = code_now;
      d.last = code_now;
      d.uart_v = 1'b1;
      d.rs_v = 1'b1;
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.red_en <= `RST_CTRL;
      q.fwd_thr <= `RST_FWD_THR;
      q.rev_thr <= `RST_REV_THR;
      q.red <= RED_NORMAL;
      q.rf_dis <= 1'b1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign fault_relay_on_o = q.relay;
  assign rf_disable_o = q.rf_dis;
  assign thermal_alarm_o = therm_alarm;
  assign power_alarm_o = q.pwr_alarm;
  assign switch_coil_o = q.coil;
  assign fault_to_partner_o = q.fwd_fault;
  assign uart_msg_valid_o = q.uart_v;
  assign uart_msg_o = q.code;
  assign rs485_msg_valid_o = q.rs_v;
  assign rs485_msg_o = q.code;
  assign irq_o = q.irq;
endmodule // fault_mute_supervisor
`default_nettype wire

//--- verification/fault_mute_supervisor_chk.sv
`include "fault_mute_regs.svh"
`default_nettype none
module fault_mute_supervisor_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [1:0] pc_fault_i,
  input wire logic lo_unlock_i,
  input wire logic mute_loop_closed_i,
  input wire logic partner_fault_i,
  input wire logic [7:0] baseplate_temp_i,
  input wire logic [7:0] internal_temp_i,
  input wire logic [7:0] supply_current_i,
  input wire logic mute_cmd_i,
  input wire logic uart_ready_i,
  input wire logic fault_relay_on_o,
  input wire logic rf_disable_o,
  input wire logic thermal_alarm_o,
  input wire logic switch_coil_o,
  input wire logic fault_to_partner_o,
  input wire logic uart_msg_valid_o,
  input wire logic [7:0] uart_msg_o
);
  // ========
  // steps
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence hot_s;
    (internal_temp_i > `TEMP_ALARM_C) [*3];
  endsequence
  // ========
  // checks
  bus_ack_a: assert property (req_s |=> wb_ack_o)
    else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack too long");
  relay_board_a: assert property ((pc_fault_i != 2'h0) [*7] |-> !fault_relay_on_o)
    else $error("relay on in board fault");
  relay_cond_a: assert property ((supply_current_i > `CURRENT_FAULT_A ||
    baseplate_temp_i > `TEMP_FAULT_C) [*3] |-> !fault_relay_on_o)
    else $error("relay on in fault");
  partner_fwd_a: assert property (!(fault_to_partner_o && fault_relay_on_o))
    else $error("partner fault mismatch");
  loop_mute_a: assert property (!mute_loop_closed_i [*6] |-> rf_disable_o)
    else $error("rf on with loop open");
  cmd_mute_a: assert property (mute_cmd_i |-> ##[1:3] rf_disable_o)
    else $error("mute ignored");
  alarm_set_a: assert property (hot_s |-> thermal_alarm_o)
    else $error("no thermal alarm");
  coil_both_a: assert property ((partner_fault_i && pc_fault_i != 2'h0) [*7]
    |-> !switch_coil_o)
    else $error("coil with both bad");
  msg_hold_a: assert property (uart_msg_valid_o && !uart_ready_i
    |=> uart_msg_valid_o && $stable(uart_msg_o))
    else $error("message dropped");
endmodule // fault_mute_supervisor_chk
`default_nettype wire

//--- verification/link_partner.sv
`default_nettype none
module link_partner (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic [7:0] msg_i,
  output logic ready_o,
  output logic [7:0] last_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_q;
  initial begin
    ready_o = 1'b0;
    last_o = 8'h00;
    wait_q = 2'h0;
  end
  // take each byte, late when slow
  always @(posedge clk_i) begin
    if (ready_o && valid_i) last_o <= msg_i;
    wait_q <= (valid_i && !ready_o) ? wait_q + 2'h1 : 2'h0;
    ready_o <= valid_i && !ready_o && (!slow_i || wait_q == 2'h2);
  end
endmodule // link_partner
`default_nettype wire

//--- verification/fault_mute_supervisor_test.sv
`include "fault_mute_regs.svh"
`default_nettype none
module fault_mute_supervisor_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
  logic [7:0] wb_adr_i, baseplate_temp_i, internal_temp_i, supply_current_i;
  logic [7:0] uart_msg_o, rs485_msg_o, uart_last, rs_last;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic lo_unlock_i, fet_fail_i, mute_loop_closed_i, partner_fault_i, mute_cmd_i;
  logic enable_cmd_i, uart_ready_i, rs485_ready_i, fault_relay_on_o, rf_disable_o;
  logic thermal_alarm_o, power_alarm_o, switch_coil_o, fault_to_partner_o;
  logic uart_msg_valid_o, rs485_msg_valid_o, irq_o;
  logic [1:0] pc_fault_i;
  logic [11:0] fwd_power_i, rev_power_i;
  logic [7:0] code_t [4] = '{8'h41, 8'h44, 8'h42, 8'h48};
  int errors, checks;
  fault_mute_supervisor dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc_fault_i(pc_fault_i),
    .lo_unlock_i(lo_unlock_i), .fet_fail_i(fet_fail_i),
    .mute_loop_closed_i(mute_loop_closed_i), .partner_fault_i(partner_fault_i),
    .baseplate_temp_i(baseplate_temp_i), .internal_temp_i(internal_temp_i),
    .supply_current_i(supply_current_i), .fwd_power_i(fwd_power_i),
    .rev_power_i(rev_power_i), .mute_cmd_i(mute_cmd_i), .enable_cmd_i(enable_cmd_i),
    .uart_ready_i(uart_ready_i), .rs485_ready_i(rs485_ready_i),
    .fault_relay_on_o(fault_relay_on_o), .rf_disable_o(rf_disable_o),
    .thermal_alarm_o(thermal_alarm_o), .power_alarm_o(power_alarm_o),
    .switch_coil_o(switch_coil_o), .fault_to_partner_o(fault_to_partner_o),
    .uart_msg_valid_o(uart_msg_valid_o), .uart_msg_o(uart_msg_o),
    .rs485_msg_valid_o(rs485_msg_valid_o), .rs485_msg_o(rs485_msg_o), .irq_o(irq_o)
  );
  link_partner uart_side (.clk_i, .slow_i(1'b0), .valid_i(uart_msg_valid_o),
    .msg_i(uart_msg_o), .ready_o(uart_ready_i), .last_o(uart_last));
  link_partner rs_side (.clk_i, .slow_i(slow), .valid_i(rs485_msg_valid_o),
    .msg_i(rs485_msg_o), .ready_o(rs485_ready_i), .last_o(rs_last));
  // ========
  // tasks
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n == 50) begin
      errors++;
      $display("mismatch bus ack exp 1 got 0");
    end
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    bus(0, a, 0);
    chk(s, e, q);
  endtask
  task automatic cond(input int i, input logic v);
    case (i)
      0: lo_unlock_i <= v;
      1: baseplate_temp_i <= v ? 8'h51 : `TEMP_FAULT_C;
      2: fet_fail_i <= v;
      default: supply_current_i <= v ? 8'h97 : `CURRENT_FAULT_A;
    endcase
  endtask
  task automatic pulse(input logic m);
    if (m) mute_cmd_i <= 1;
    else enable_cmd_i <= 1;
    wt(1);
    mute_cmd_i <= 0;
    enable_cmd_i <= 0;
    wt(4);
  endtask
  task automatic end_of_test;
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ========
  // run
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #3000000;
    errors++;
    $display("mismatch watchdog exp done got running");
    end_of_test;
  end
  initial begin
    {errors, checks, slow, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i} = 0;
    {wb_adr_i, wb_sel_i, wb_dat_i, pc_fault_i, lo_unlock_i, fet_fail_i} = 0;
    {partner_fault_i, mute_cmd_i, enable_cmd_i, fwd_power_i, rev_power_i} = 0;
    {rst_i, ce_i, wb_sel_i, mute_loop_closed_i} = 7'h7f;
    {internal_temp_i, baseplate_temp_i} = {8'h00, `TEMP_FAULT_C};
    supply_current_i = `CURRENT_FAULT_A;
    wt(12);
    rst_i <= 0;
    rd(`OFF_CTRL, 32'h1, "ctrl");
    rd(`OFF_REV_THR, 32'hfff, "rev thr");
    rd(8'h18, 32'h0, "unmapped");
    bus(1, `OFF_IRQ_MASK, 32'hf);
    for (int i = 0; i < 4; i++) begin
      chk("relay idle", 1, fault_relay_on_o);
      chk("partner idle", 0, fault_to_partner_o);
      cond(i, 1);
      wt(10);
      chk("relay", 0, fault_relay_on_o);
      chk("partner", 1, fault_to_partner_o);
      chk("uart", code_t[i], uart_last);
      chk("rs485", code_t[i], rs_last);
      cond(i, 0);
      wt(10);
      chk("code clr", 0, uart_last);
    end
    chk("irq", 1, irq_o);
    bus(1, `OFF_IRQ_STAT, 32'h1);
    wt(2);
    chk("irq clr", 0, irq_o);
    bus(1, `OFF_IRQ_MASK, 32'h0);
    slow <= 1;
    pc_fault_i <= 2'b01;
    wt(3);
    lo_unlock_i <= 1;
    wt(10);
    chk("relay pc", 0, fault_relay_on_o);
    chk("masked", 0, irq_o);
    pc_fault_i <= 2'b00;
    wt(16);
    chk("relay lo", 0, fault_relay_on_o);
    chk("rs slow", 8'h41, rs_last);
    lo_unlock_i <= 0;
    wt(16);
    chk("relay on", 1, fault_relay_on_o);
    rd(`OFF_IRQ_STAT, 32'h1, "irq stat");
    internal_temp_i <= 8'h47;
    wt(4);
    chk("alarm", 1, thermal_alarm_o);
    chk("rf alarm", 0, rf_disable_o);
    internal_temp_i <= 8'h51;
    wt(4);
    chk("shutdown", 1, rf_disable_o);
    internal_temp_i <= 8'h42;
    wt(4);
    chk("cooling", 1, rf_disable_o);
    internal_temp_i <= `TEMP_RESTART_C;
    wt(4);
    chk("restart", 0, rf_disable_o);
    chk("alarm off", 0, thermal_alarm_o);
    bus(1, `OFF_FWD_THR, 32'h100);
    bus(1, `OFF_REV_THR, 32'h200);
    fwd_power_i <= 12'h0ff;
    wt(3);
    chk("fwd low", 1, power_alarm_o);
    {fwd_power_i, rev_power_i} <= {12'h100, 12'h201};
    wt(3);
    chk("rev high", 1, power_alarm_o);
    rev_power_i <= 12'h200;
    wt(3);
    chk("pwr ok", 0, power_alarm_o);
    ce_i <= 0;
    rev_power_i <= 12'h201;
    wt(4);
    chk("ce hold", 0, power_alarm_o);
    ce_i <= 1;
    wt(3);
    chk("ce run", 1, power_alarm_o);
    rev_power_i <= 12'h200;
    wt(3);
    mute_loop_closed_i <= 0;
    wt(6);
    chk("loop", 1, rf_disable_o);
    pulse(0);
    chk("ser en", 1, rf_disable_o);
    rst_i <= 1;
    wt(2);
    rst_i <= 0;
    wt(8);
    chk("reboot", 1, rf_disable_o);
    mute_loop_closed_i <= 1;
    wt(6);
    chk("closed", 0, rf_disable_o);
    pulse(1);
    chk("ser mute", 1, rf_disable_o);
    pulse(0);
    chk("ser on", 0, rf_disable_o);
    partner_fault_i <= 1;
    wt(7);
    chk("coil", 1, switch_coil_o);
    bus(0, `OFF_STATUS, 0);
    chk("takeover", 3'b010, q[10:8]);
    bus(1, `OFF_CTRL, 32'h0);
    wt(2);
    chk("red off", 0, switch_coil_o);
    bus(1, `OFF_CTRL, 32'h1);
    wt(2);
    chk("red on", 1, switch_coil_o);
    pc_fault_i <= 2'b10;
    wt(7);
    chk("both bad", 0, switch_coil_o);
    partner_fault_i <= 0;
    wt(7);
    chk("own bad", 0, switch_coil_o);
    pc_fault_i <= 0;
    wt(7);
    chk("normal", 0, switch_coil_o);
    end_of_test;
  end
endmodule // fault_mute_supervisor_test
bind fault_mute_supervisor fault_mute_supervisor_chk chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .pc_fault_i(pc_fault_i), .lo_unlock_i(lo_unlock_i),
  .mute_loop_closed_i(mute_loop_closed_i), .partner_fault_i(partner_fault_i),
  .baseplate_temp_i(baseplate_temp_i), .internal_temp_i(internal_temp_i),
  .supply_current_i(supply_current_i), .mute_cmd_i(mute_cmd_i),
  .uart_ready_i(uart_ready_i), .fault_relay_on_o(fault_relay_on_o),
  .rf_disable_o(rf_disable_o), .thermal_alarm_o(thermal_alarm_o),
  .switch_coil_o(switch_coil_o), .fault_to_partner_o(fault_to_partner_o),
  .uart_msg_valid_o(uart_msg_valid_o), .uart_msg_o(uart_msg_o)
);
`default_nettype wire
